// [inc/isl_pkg.sv]
// Package for the two-wire serial bus slave engine
package isl_pkg;
	// Fixed upper address nibble
	localparam logic [3:0] ISL_ADDR_HI = 4'h4;
	// Bits per byte, counter width
	localparam logic [3:0] ISL_BYTE_BITS = 4'h8;
	// System clock and bus timing
	localparam int ISL_CLK_HZ = 10_000_000;
	localparam int ISL_SCL_MAX_HZ = 100_000;
	localparam int ISL_SCL_MIN_CYC = ISL_CLK_HZ / ISL_SCL_MAX_HZ;
	// Synchroniser reset level (lines idle high)
	localparam logic [2:0] ISL_SYNC_RST = 3'h7;

	// Bus events, one-cycle pulses, plus the filtered SDA level
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} isl_ev_t;

	// Slave protocol states
	typedef enum logic [2:0] {
		ISL_IDLE,
		ISL_ADDR,
		ISL_ACK,
		ISL_RX,
		ISL_TX,
		ISL_MACK,
		ISL_IGNORE
	} isl_state_t;
endpackage

// [verilog/isl_line_mon.sv]
// Line synchroniser and edge/condition detector for SCL and SDA
`timescale 1ns/10ps
module isl_line_mon
	import isl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Raw bus lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Detected events
	output isl_ev_t ev
);
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic scl_q_r;
	logic sda_q_r;
	logic scl_agree;
	logic sda_agree;
	logic scl_nxt;
	logic sda_nxt;
	logic serial_clock_rise_pulse;
	logic serial_clock_fall_pulse;
	logic start_pulse;
	logic stop_pulse;

	// Three-stage synchronisers, stage 0 read only by stage 1
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_s_r <= ISL_SYNC_RST;
			sda_s_r <= ISL_SYNC_RST;
		end else begin
			scl_s_r <= {scl_s_r[1:0], scl_in};
			sda_s_r <= {sda_s_r[1:0], sda_in};
		end
	end

	// A change counts once stages two and three agree
	assign scl_agree = (scl_s_r[1] == scl_s_r[2]);
	assign sda_agree = (sda_s_r[1] == sda_s_r[2]);
	assign scl_nxt = scl_agree ? scl_s_r[2] : scl_q_r;
	assign sda_nxt = sda_agree ? sda_s_r[2] : sda_q_r;

	// Filtered line levels
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_nxt;
			sda_q_r <= sda_nxt;
		end
	end

	// Single-cycle edge and condition pulses, one driver for the bundle
	assign serial_clock_rise_pulse = scl_nxt & ~scl_q_r;
	assign serial_clock_fall_pulse = ~scl_nxt & scl_q_r;
	assign start_pulse = scl_q_r & scl_nxt & sda_q_r & ~sda_nxt;
	assign stop_pulse = scl_q_r & scl_nxt & ~sda_q_r & sda_nxt;
	assign ev = '{start: start_pulse, stop: stop_pulse,
		scl_rise: serial_clock_rise_pulse,
		scl_fall: serial_clock_fall_pulse, sda: sda_nxt};
endmodule

// [verilog/isl_slave.sv]
// Two-wire serial bus slave protocol engine, receiver and transmitter
// Contract
// - One data bit per clock pulse
// - SDA changes only while SCL low
// - Idle bus leaves both lines high
// - SDA fall, SCL high: start
// - SDA rise, SCL high: stop, release
// - Unlimited bytes between start and stop
// - Eight bits plus one acknowledge slot
// - Sender releases SDA in acknowledge slot
// - Addressed receiver acknowledges every byte
// - Acknowledger holds SDA low whole pulse
// - Transmitter releases SDA on no acknowledge
// - First byte: seven-bit address, direction
// - Direction bit: zero write, one read
// - Restart opens fresh address phase
// - Address is 0100 plus three pins
// - Advance only on SCL edge pulses; start and stop conditions also move the state here
`timescale 1ns/10ps
module isl_slave
	import isl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus lines, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic scl_out,
	output logic scl_oe,
	// Address select pins
	input wire logic [2:0] addr_sel,
	// Data to send while read by master
	input wire logic [7:0] tx_data,
	output logic tx_taken,
	// Data received while written by master
	output logic [7:0] rx_data,
	output logic rx_valid,
	// Status
	output logic busy,
	output logic selected,
	output logic transfer_direction_bit
);
	isl_ev_t ev;
	isl_state_t state_r, state_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic pull_r, pull_nxt;
	logic dir_r, dir_nxt;
	logic busy_r, busy_nxt;
	logic [7:0] rx_r, rx_nxt;
	logic rxv_r, rxv_nxt;
	logic txt_r, txt_nxt;
	logic [2:0] asel_s0_r, asel_s1_r, asel_s2_r;
	logic [2:0] asel_r, asel_nxt;
	logic sel_r, sel_nxt;
	logic addr_hit;
	logic byte_done;
	logic [6:0] own_addr;

	// Line monitor
	isl_line_mon u_mon (
		.clk(clk),
		.rstn(rstn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev)
	);

	// Address pins come from outside; three flops, two and three agree
	assign asel_nxt = (asel_s1_r == asel_s2_r) ? asel_s2_r : asel_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			asel_s0_r <= 3'h0;
			asel_s1_r <= 3'h0;
			asel_s2_r <= 3'h0;
			asel_r <= 3'h0;
		end else begin
			asel_s0_r <= addr_sel;
			asel_s1_r <= asel_s0_r;
			asel_s2_r <= asel_s1_r;
			asel_r <= asel_nxt;
		end
	end

	assign own_addr = {ISL_ADDR_HI, asel_r};
	assign addr_hit = (sh_r[7:1] == own_addr);
	assign byte_done = (bit_r == ISL_BYTE_BITS);

	// Protocol state machine, moves only on edge pulses and conditions
	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		pull_nxt = pull_r;
		dir_nxt = dir_r;
		busy_nxt = busy_r;
		rx_nxt = rx_r;
		rxv_nxt = 1'b0;
		txt_nxt = 1'b0;
		if (ev.stop) begin
			state_nxt = ISL_IDLE;
			pull_nxt = 1'b0;
			busy_nxt = 1'b0;
		end else if (ev.start) begin
			state_nxt = ISL_ADDR;
			bit_nxt = 4'h0;
			pull_nxt = 1'b0;
			busy_nxt = 1'b1;
		end else begin
			case (state_r)
			ISL_ADDR, ISL_RX: begin
				// Sample on rise, one bit per pulse, MSB first
				if (ev.scl_rise && !byte_done) begin
					sh_nxt = {sh_r[6:0], ev.sda};
					bit_nxt = bit_r + 4'h1;
				end else if (ev.scl_fall && byte_done) begin
					bit_nxt = 4'h0;
					if (state_r == ISL_ADDR) begin
						if (addr_hit) begin
							dir_nxt = sh_r[0];
							pull_nxt = 1'b1;
							state_nxt = ISL_ACK;
						end else begin
							state_nxt = ISL_IGNORE;
						end
					end else begin
						rx_nxt = sh_r;
						rxv_nxt = 1'b1;
						pull_nxt = 1'b1;
						state_nxt = ISL_ACK;
					end
				end
			end
			ISL_ACK: begin
				// Held low across the whole acknowledge pulse
				if (ev.scl_fall) begin
					if (dir_r) begin
						sh_nxt = tx_data;
						txt_nxt = 1'b1;
						pull_nxt = ~tx_data[7];
						bit_nxt = 4'h1;
						state_nxt = ISL_TX;
					end else begin
						pull_nxt = 1'b0;
						state_nxt = ISL_RX;
					end
				end
			end
			ISL_TX: begin
				// Shift next bit while SCL low
				if (ev.scl_fall) begin
					if (byte_done) begin
						pull_nxt = 1'b0;
						bit_nxt = 4'h0;
						state_nxt = ISL_MACK;
					end else begin
						sh_nxt = {sh_r[6:0], 1'b0};
						pull_nxt = ~sh_r[6];
						bit_nxt = bit_r + 4'h1;
					end
				end
			end
			ISL_MACK: begin
				// Master acknowledge decides whether to continue
				if (ev.scl_rise) begin
					if (ev.sda)
						state_nxt = ISL_IGNORE;
					else
						state_nxt = ISL_ACK;
					dir_nxt = 1'b1;
					pull_nxt = 1'b0;
				end
			end
			default: begin
				pull_nxt = 1'b0;
			end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ISL_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			pull_r <= 1'b0;
			dir_r <= 1'b0;
			busy_r <= 1'b0;
			sel_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			pull_r <= pull_nxt;
			dir_r <= dir_nxt;
			busy_r <= busy_nxt;
			sel_r <= sel_nxt;
		end
	end

	// Output registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_r <= 8'h00;
			rxv_r <= 1'b0;
			txt_r <= 1'b0;
		end else begin
			rx_r <= rx_nxt;
			rxv_r <= rxv_nxt;
			txt_r <= txt_nxt;
		end
	end

	// Open-drain drive: output always low, enable pulls
	assign sda_out = 1'b0;
	assign sda_oe = pull_r;
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign rx_data = rx_r;
	assign rx_valid = rxv_r;
	assign tx_taken = txt_r;
	assign busy = busy_r;
	assign transfer_direction_bit = dir_r;
	assign selected = sel_r;

	// Addressed states, registered so the output comes from a flop
	assign sel_nxt = (state_nxt == ISL_ACK) || (state_nxt == ISL_RX) ||
		(state_nxt == ISL_TX) || (state_nxt == ISL_MACK);

	// Assertions
	AST_STOP_RELEASE: assert property (@(posedge clk)
		disable iff (!rstn) ev.stop |=> !sda_oe && state_r == ISL_IDLE)
		else $error("SDA not released after stop");
	AST_START_ADDR: assert property (@(posedge clk)
		disable iff (!rstn) ev.start && !ev.stop
		|=> state_r == ISL_ADDR && bit_r == 4'h0)
		else $error("Start did not open address phase");
	AST_HOLD_NO_EDGE: assert property (@(posedge clk)
		disable iff (!rstn)
		!ev.scl_rise && !ev.scl_fall && !ev.start && !ev.stop
		|=> $stable(state_r))
		else $error("State moved without an edge");
	AST_ACK_ADDR: assert property (@(posedge clk)
		disable iff (!rstn)
		state_r == ISL_ADDR && ev.scl_fall && byte_done && !ev.start &&
		!ev.stop && addr_hit |=> sda_oe)
		else $error("Matching address not acknowledged");
	AST_NO_ACK_MISS: assert property (@(posedge clk)
		disable iff (!rstn)
		state_r == ISL_ADDR && ev.scl_fall && byte_done && !addr_hit &&
		!ev.start && !ev.stop |=> !sda_oe && state_r == ISL_IGNORE)
		else $error("Mismatched address acknowledged");
	AST_IGNORE_QUIET: assert property (@(posedge clk)
		disable iff (!rstn) state_r == ISL_IGNORE |=> !sda_oe)
		else $error("SDA driven while ignoring");
	AST_DIR: assert property (@(posedge clk)
		disable iff (!rstn) state_r == ISL_ADDR && state_nxt == ISL_ACK
		|=> dir_r == $past(sh_r[0]))
		else $error("Direction bit decoded wrongly");
	AST_SDA_STABLE: assert property (@(posedge clk)
		disable iff (!rstn) ev.scl_rise && state_r == ISL_TX |=> $stable(sda_oe))
		else $error("SDA drive changed with SCL high");
	AST_RX_PULSE: assert property (@(posedge clk)
		disable iff (!rstn) rx_valid |=> !rx_valid && sda_oe)
		else $error("Receive pulse malformed");
	AST_SDA_LOW_ONLY: assert property (@(posedge clk)
		disable iff (!rstn) sda_out == 1'b0)
		else $error("SDA driven high");
	AST_ACK_HOLD: assert property (@(posedge clk)
		disable iff (!rstn)
		state_r == ISL_ACK && !ev.scl_fall && !ev.start && !ev.stop
		|=> $stable(sda_oe))
		else $error("Acknowledge drive changed inside the slot");
	AST_TX_RELEASE: assert property (@(posedge clk)
		disable iff (!rstn)
		state_r == ISL_TX && ev.scl_fall && byte_done && !ev.start &&
		!ev.stop |=> !sda_oe && state_r == ISL_MACK)
		else $error("SDA not released for master acknowledge");
	AST_NACK_END: assert property (@(posedge clk)
		disable iff (!rstn)
		state_r == ISL_MACK && ev.scl_rise && ev.sda && !ev.start &&
		!ev.stop |=> !sda_oe && state_r == ISL_IGNORE)
		else $error("Transmitter kept driving after no acknowledge");
	AST_BIT_RANGE: assert property (@(posedge clk)
		disable iff (!rstn) bit_r <= ISL_BYTE_BITS)
		else $error("Bit counter past one byte");
	AST_RX_DATA: assert property (@(posedge clk)
		disable iff (!rstn) rx_valid |-> rx_data == $past(sh_r))
		else $error("Received byte differs from shifted bits");
	AST_TX_FIRST: assert property (@(posedge clk)
		disable iff (!rstn) tx_taken |-> sda_oe == !$past(tx_data[7]))
		else $error("First transmit bit not on SDA");
	AST_IDLE_QUIET: assert property (@(posedge clk)
		disable iff (!rstn) state_r == ISL_IDLE |-> !sda_oe)
		else $error("SDA pulled while idle");
	COV_READ: cover property (@(posedge clk) disable iff (!rstn)
		state_r == ISL_MACK ##1 state_r == ISL_ACK);
	COV_WRITE: cover property (@(posedge clk) rx_valid);
	COV_NACK_END: cover property (@(posedge clk)
		state_r == ISL_MACK ##1 state_r == ISL_IGNORE);
	COV_RESTART: cover property (@(posedge clk) busy_r && ev.start);
	COV_MISMATCH: cover property (@(posedge clk) disable iff (!rstn)
		state_r == ISL_ADDR ##1 state_r == ISL_IGNORE);
endmodule

// [bench/isl_master.sv]
// Bus master model driving SCL and SDA through open-drain enables
`timescale 1ns/10ps
module isl_master (
	// Clock and resolved data line
	input wire logic clk,
	input wire logic sda_in,
	// Pull-low enables
	output logic scl_oe,
	output logic sda_oe
);
	// Quarter bit at 100 kHz on a 10 MHz clock
	localparam int Q = 25;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Start or repeated start, SDA falls with SCL high
	task automatic start();
		sda_oe = 1'b0;
		q(Q);
		scl_oe = 1'b0;
		q(Q);
		sda_oe = 1'b1;
		q(Q);
		scl_oe = 1'b1;
		q(Q);
	endtask
	// Stop, then both lines left high
	task automatic stop();
		sda_oe = 1'b1;
		q(Q);
		scl_oe = 1'b0;
		q(Q);
		sda_oe = 1'b0;
		q(2 * Q);
	endtask
	// One bit per pulse, data set while SCL low
	task automatic bitx(input logic b, output logic r);
		sda_oe = !b;
		q(Q);
		scl_oe = 1'b0;
		q(Q);
		r = sda_in;
		q(Q);
		scl_oe = 1'b1;
		q(Q);
	endtask
	// Eight bits MSB first plus one acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(a, k);
	endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the serial bus slave engine
`timescale 1ns/10ps
module tb_top;
	import isl_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] addr_sel = 3'h5;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] tx_q [4] = '{8'ha5, 8'h3c, 8'h96, 8'h5a};
	logic [7:0] rx_last = 8'h00;
	logic [7:0] rx_data;
	logic scl_w, sda_w, m_scl_oe, m_sda_oe, sda_out, sda_oe, scl_out;
	logic scl_oe, tx_taken, rx_valid, busy, selected, dir;
	int miscompares = 0;
	int cmp_count = 0;
	int tx_idx = 0;
	int rx_cnt = 0;
	// Wired-AND lines with pull-ups
	assign scl_w = !(m_scl_oe || (scl_oe && !scl_out));
	assign sda_w = !(m_sda_oe || (sda_oe && !sda_out));
	always #50 clk = !clk;
	isl_slave uut (.clk(clk), .rstn(rstn), .scl_in(scl_w), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
		.scl_oe(scl_oe), .addr_sel(addr_sel), .tx_data(tx_data),
		.tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid),
		.busy(busy), .selected(selected), .transfer_direction_bit(dir));
	isl_master m_bus (.clk(clk), .sda_in(sda_w), .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe));
	// Capture received bytes
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rx_last <= rx_data;
			rx_cnt <= rx_cnt + 1;
		end
	end
	// Next byte to send after each capture
	always @(negedge clk) begin
		if (tx_taken === 1'b1)
			tx_idx <= tx_idx + 1;
		tx_data <= tx_q[tx_idx % 4];
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string m);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t ns: %s", $time, m);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Write address then three bytes
	task automatic t_write();
		logic [7:0] r;
		logic k;
		logic [7:0] d [3] = '{8'h81, 8'h00, 8'hff};
		m_bus.start();
		m_bus.xfer({ISL_ADDR_HI, addr_sel, 1'b0}, 1'b1, r, k);
		chk(8'(k), 8'h00, "write address not acked");
		chk(8'(dir), 8'h00, "direction not write");
		chk(8'(busy), 8'h01, "not busy after start");
		chk(8'(selected), 8'h01, "not selected on match");
		chk(8'({scl_oe, scl_out, sda_out}), 8'h00, "lines driven");
		for (int i = 0; i < 3; i++) begin
			m_bus.xfer(d[i], 1'b1, r, k);
			chk(8'(k), 8'h00, "data byte not acked");
			chk(rx_last, d[i], "received byte wrong");
		end
		m_bus.stop();
		chk(8'(busy), 8'h00, "busy after stop");
		chk(8'(sda_oe), 8'h00, "SDA held after stop");
	endtask
	// Wrong addresses are ignored
	task automatic t_mismatch();
		logic [7:0] r;
		logic k;
		int n0;
		logic [7:0] a [2];
		a[0] = {ISL_ADDR_HI, addr_sel ^ 3'h1, 1'b0};
		a[1] = {4'h5, addr_sel, 1'b0};
		n0 = rx_cnt;
		for (int j = 0; j < 2; j++) begin
			m_bus.start();
			m_bus.xfer(a[j], 1'b1, r, k);
			chk(8'(k), 8'h01, "foreign address acked");
			chk(8'(selected), 8'h00, "selected on mismatch");
			m_bus.xfer(8'h00, 1'b1, r, k);
			chk(8'(k), 8'h01, "ignored byte acked");
			m_bus.stop();
		end
		chk(8'(rx_cnt - n0), 8'h00, "bytes taken while ignored");
	endtask
	// Read: with rs ack one byte, nack the next, then SDA released
	task automatic t_read(input logic rs);
		logic [7:0] r;
		logic k;
		int n0;
		int t0;
		n0 = tx_idx;
		t0 = tx_idx;
		m_bus.start();
		m_bus.xfer({ISL_ADDR_HI, addr_sel, 1'b1}, 1'b1, r, k);
		chk(8'(k), 8'h00, "read address not acked");
		chk(8'(dir), 8'h01, "direction not read");
		if (rs) begin
			m_bus.xfer(8'hff, 1'b0, r, k);
			chk(r, tx_q[n0 % 4], "first read byte wrong");
			n0++;
		end
		m_bus.xfer(8'hff, 1'b1, r, k);
		chk(r, tx_q[n0 % 4], "last read byte wrong");
		m_bus.xfer(8'hff, 1'b1, r, k);
		chk(r, 8'hff, "SDA driven after nack");
		m_bus.stop();
		chk(8'(busy), 8'h00, "busy after read stop");
		chk(8'(tx_idx - t0), rs ? 8'h02 : 8'h01, "bytes taken wrong");
	endtask
	// Write one byte, then repeated start into a read
	task automatic t_restart();
		logic [7:0] r;
		logic k;
		m_bus.start();
		m_bus.xfer({ISL_ADDR_HI, addr_sel, 1'b0}, 1'b1, r, k);
		chk(8'(k), 8'h00, "restart write address not acked");
		m_bus.xfer(8'h42, 1'b1, r, k);
		chk(rx_last, 8'h42, "byte before restart wrong");
		m_bus.bitx(1'b1, k);
		t_read(1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		t_write();
		t_mismatch();
		t_read(1'b1);
		t_restart();
		results();
	end
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		$display("Error at %0t ns: run did not finish", $time);
		results();
	end
endmodule
